//--- hdl/dris_pkg.sv
// Constants, register map and types of the reference input selector
// Assumes a 25 MHz control clock and an APB register bus
package dris_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int NUM_REFS = 4;
    localparam int IDX_W    = 2;
    localparam int PRIO_W   = 4;
    localparam int CMPF_W   = 4;
    localparam int VT_W     = 8;
    localparam int MON_W    = 4;
    localparam int INT_W    = 4;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_MAN_SEL = 8'h04;
    localparam logic [7:0] ADDR_PRIO    = 8'h08;
    localparam logic [7:0] ADDR_INCFG   = 8'h0C;
    localparam logic [7:0] ADDR_VALTIME = 8'h10;
    localparam logic [7:0] ADDR_MONEN   = 8'h14;
    localparam logic [7:0] ADDR_CMPF    = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1C;
    localparam logic [7:0] ADDR_INT_ST  = 8'h20;
    localparam logic [7:0] ADDR_INT_EN  = 8'h24;
    localparam logic [7:0] ADDR_INT_CLR = 8'h28;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_PIN_SEL    = 2;
    localparam int CTRL_HITLESS_EN = 3;
    localparam int CTRL_SLEW_SEL   = 4;
    localparam int INCFG_FIELD_W   = 5;
    localparam int INCFG_DC_BIT    = 4;
    localparam int ST_SEL_LSB      = 0;
    localparam int ST_ACTIVE       = 2;
    localparam int ST_HOLDOVER     = 3;
    localparam int ST_FREERUN      = 4;
    localparam int ST_VALID_LSB    = 8;
    localparam int INT_SWITCH      = 0;
    localparam int INT_HOLDOVER    = 1;
    localparam int INT_FREERUN     = 2;
    localparam int INT_VALID_CHG   = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] PRIO_RESET    = 32'h0000_3210;
    localparam logic [31:0] VALTIME_RESET = 32'h1010_1010;
    localparam logic [31:0] MONEN_RESET   = 32'h0000_FFFF;
    localparam logic [31:0] ZERO_RESET    = 32'h0000_0000;

    // ----------------------------------------
    // Input type codes
    // ----------------------------------------
    localparam logic [3:0] TYPE_DC_DIFF     = 4'h0;
    localparam logic [3:0] TYPE_AC_DIFF     = 4'h1;
    localparam logic [3:0] TYPE_DC_DIFF_T   = 4'h2;
    localparam logic [3:0] TYPE_AC_DIFF_T   = 4'h3;
    localparam logic [3:0] TYPE_DC_SE50     = 4'h4;
    localparam logic [3:0] TYPE_AC_SE50     = 4'h5;
    localparam logic [3:0] TYPE_LOGIC       = 4'h8;
    localparam logic [3:0] TYPE_LOGIC_T50   = 4'hC;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        MODE_AUTO_REV,
        MODE_AUTO_NONREV,
        MODE_MAN_FALLBACK,
        MODE_MAN_HOLDOVER
    } dris_mode_e;

    typedef enum logic [1:0]
    {
        SEL_FREERUN,
        SEL_TRACK,
        SEL_HOLDOVER
    } dris_state_e;

endpackage

//--- hdl/dris_qualifier.sv
// Validation timer for one reference input
// Assumes monitor flags synchronous to the clock and a slow tick enable
`timescale 1ns/100ps
module dris_qualifier
#(
    parameter int VT_W  = 8,
    parameter int MON_W = 4
)
(
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_resetn,
    // Timing
    input  wire logic             i_tick,
    input  wire logic [VT_W-1:0]  i_val_time,
    // Monitors
    input  wire logic [MON_W-1:0] i_flags,
    input  wire logic [MON_W-1:0] i_mon_en,
    // Result
    output logic                  o_valid
);

    logic [VT_W-1:0] count;
    logic            flagged;

    // Disabled monitors are ignored entirely
    assign flagged = |(i_flags & i_mon_en);

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            count   <= '0;
            o_valid <= 1'b0;
        end
        else if (flagged)
        begin
            count   <= '0;
            o_valid <= 1'b0;
        end
        else if (i_tick && !o_valid)
        begin
            if (count >= i_val_time)
                o_valid <= 1'b1;
            else
                count <= count + 1'b1;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    chk_flag_drops_valid: assert property (flagged |=> !o_valid)
        else $error("input stayed valid after a monitor flag");
    chk_valid_needs_time: assert property (
        $rose(o_valid) |-> $past(count) >= $past(i_val_time))
        else $error("input qualified before its validation time");

endmodule

//--- hdl/dris_top.sv
// Reference input configuration and selection for one DPLL
// Assumes APB from software, monitor flags and DPLL history flag
// synchronous to I_CLOCK
//
// What this block does
// - Any of four inputs can drive DPLL
// - Switch only between common comparison frequencies, except to manual choice after failure
// - Type codes 0-5 set termination and bias
// - Logic type uses AC path or bypass
// - Amplitude detector on only for type codes 0-5 with the DC bit clear
// - Revertive picks best valid, switches up immediately
// - Non-revertive keeps input until it fails
// - Manual choice from register or pins
// - Fallback moves to best valid on failure
// - No valid input: holdover if history, else free-run
// - Manual holdover mode never tries other inputs
// - Manual choice valid again resumes tracking
// - Hitless by cancellation or slew, configurable
// - Hitless off passes phase step through
// - Valid only after monitors clear for timer
`timescale 1ns/100ps
module dris_top
#(
    parameter int NUM_REFS = dris_pkg::NUM_REFS
)
(
    // Clock and reset
    input  wire logic                I_CLOCK,
    input  wire logic                I_RESETN,
    // APB slave
    input  wire logic                I_PSEL,
    input  wire logic                I_PENABLE,
    input  wire logic                I_PWRITE,
    input  wire logic [7:0]          I_PADDR,
    input  wire logic [31:0]         I_PWDATA,
    output logic [31:0]              O_PRDATA,
    output logic                     O_PREADY,
    output logic                     O_PSLVERR,
    // Reference inputs and monitors
    input  wire logic [NUM_REFS-1:0] I_REF_CLK_IN,
    input  wire logic [15:0]         I_MON_FLAGS,
    input  wire logic [1:0]          I_MAN_SEL_PINS,
    input  wire logic                I_TUNE_HIST_VALID,
    // Input buffer switches
    output logic [NUM_REFS-1:0]      O_SE_TERM_SWITCH,
    output logic [NUM_REFS-1:0]      O_DIFF_TERM_SWITCH,
    output logic [NUM_REFS-1:0]      O_BIAS_SWITCH,
    output logic [NUM_REFS-1:0]      O_AC_CAP_BYPASS_SWITCH,
    output logic [NUM_REFS-1:0]      O_AMP_DET_EN,
    // DPLL side
    output logic                     O_REF_CLK,
    output logic [1:0]               O_REF_SEL,
    output logic                     O_REF_ACTIVE,
    output logic                     O_HOLDOVER,
    output logic                     O_FREERUN,
    output logic                     O_SWITCHOVER,
    output logic                     O_HITLESS_CANCEL,
    output logic                     O_HITLESS_SLEW,
    output logic                     O_PHASE_STEP,
    // Interrupt
    output logic                     O_IRQ
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Returns {amp, s4, s3, s2, s1}; unknown codes leave all off
    function automatic logic [4:0] buf_decode(input logic dc,
                                              input logic [3:0] t);
        logic [4:0] r;
        r = 5'h00;
        if (!dc)
        begin
            unique case (t)
                dris_pkg::TYPE_DC_DIFF:   r = 5'b10000;
                dris_pkg::TYPE_AC_DIFF:   r = 5'b10100;
                dris_pkg::TYPE_DC_DIFF_T: r = 5'b10010;
                dris_pkg::TYPE_AC_DIFF_T: r = 5'b10110;
                dris_pkg::TYPE_DC_SE50:   r = 5'b10001;
                dris_pkg::TYPE_AC_SE50:   r = 5'b10101;
                dris_pkg::TYPE_LOGIC:     r = 5'b00000;
                default:                  r = 5'h00;
            endcase
        end
        else if (t == dris_pkg::TYPE_LOGIC)
            r = 5'b01000;
        else if (t == dris_pkg::TYPE_LOGIC_T50)
            r = 5'b01001;
        return r;
    endfunction

    // Returns {found, index}; lower priority code wins, ties go low
    function automatic logic [2:0] pick_best(input logic [3:0] elig,
                                             input logic [15:0] prio);
        logic [2:0] r;
        logic [3:0] bp;
        r  = 3'b000;
        bp = 4'hF;
        for (int i = 0; i < 4; i++)
        begin
            if (elig[i] && (!r[2] || prio[i*4 +: 4] < bp))
            begin
                r  = {1'b1, 2'(i)};
                bp = prio[i*4 +: 4];
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [4:0]  ctrl;
    logic [1:0]  man_sel;
    logic [15:0] prio;
    logic [19:0] incfg;
    logic [31:0] valtime;
    logic [15:0] monen;
    logic [15:0] cmpf;
    logic [3:0]  int_stat;
    logic [3:0]  int_en;
    logic [31:0] rd_data;
    logic        addr_ok;
    logic        setup;
    logic        wr_fire;

    assign setup   = I_PSEL && !I_PENABLE;
    assign wr_fire = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                     && !O_PSLVERR;

    // ----------------------------------------
    // Selection state
    // ----------------------------------------
    dris_pkg::dris_state_e state;
    dris_pkg::dris_state_e next_state;
    dris_pkg::dris_mode_e  mode;
    logic [1:0]  sel;
    logic [1:0]  next_sel;
    logic [1:0]  man_target;
    logic [3:0]  ref_valid;
    logic [3:0]  valid_prev;
    logic [3:0]  compat;
    logic [3:0]  elig;
    logic [2:0]  best;
    logic        do_switch;
    logic [3:0]  events;
    logic [4:0]  tick_cnt;
    logic        tick;

    always_comb
    begin
        rd_data = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (I_PADDR)
            dris_pkg::ADDR_CTRL:    rd_data = {27'h0, ctrl};
            dris_pkg::ADDR_MAN_SEL: rd_data = {30'h0, man_sel};
            dris_pkg::ADDR_PRIO:    rd_data = {16'h0, prio};
            dris_pkg::ADDR_INCFG:   rd_data = {12'h0, incfg};
            dris_pkg::ADDR_VALTIME: rd_data = valtime;
            dris_pkg::ADDR_MONEN:   rd_data = {16'h0, monen};
            dris_pkg::ADDR_CMPF:    rd_data = {16'h0, cmpf};
            dris_pkg::ADDR_STATUS:  rd_data = {20'h0, ref_valid, 3'h0,
                O_FREERUN, O_HOLDOVER, O_REF_ACTIVE, O_REF_SEL};
            dris_pkg::ADDR_INT_ST:  rd_data = {28'h0, int_stat};
            dris_pkg::ADDR_INT_EN:  rd_data = {28'h0, int_en};
            dris_pkg::ADDR_INT_CLR: rd_data = 32'h0000_0000;
            default:                addr_ok = 1'b0;
        endcase
    end

    // One wait-free access phase: answer registered in the setup cycle
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            O_PREADY  <= setup;
            O_PSLVERR <= setup && !addr_ok;
            O_PRDATA  <= (setup && !I_PWRITE) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            ctrl    <= dris_pkg::CTRL_RESET[4:0];
            man_sel <= dris_pkg::ZERO_RESET[1:0];
            prio    <= dris_pkg::PRIO_RESET[15:0];
            incfg   <= dris_pkg::ZERO_RESET[19:0];
            valtime <= dris_pkg::VALTIME_RESET;
            monen   <= dris_pkg::MONEN_RESET[15:0];
            cmpf    <= dris_pkg::ZERO_RESET[15:0];
            int_en  <= dris_pkg::ZERO_RESET[3:0];
        end
        else if (wr_fire)
        begin
            unique case (I_PADDR)
                dris_pkg::ADDR_CTRL:    ctrl    <= I_PWDATA[4:0];
                dris_pkg::ADDR_MAN_SEL: man_sel <= I_PWDATA[1:0];
                dris_pkg::ADDR_PRIO:    prio    <= I_PWDATA[15:0];
                dris_pkg::ADDR_INCFG:   incfg   <= I_PWDATA[19:0];
                dris_pkg::ADDR_VALTIME: valtime <= I_PWDATA;
                dris_pkg::ADDR_MONEN:   monen   <= I_PWDATA[15:0];
                dris_pkg::ADDR_CMPF:    cmpf    <= I_PWDATA[15:0];
                dris_pkg::ADDR_INT_EN:  int_en  <= I_PWDATA[3:0];
                default:                ;
            endcase
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            int_stat <= 4'h0;
            O_IRQ    <= 1'b0;
        end
        else
        begin
            int_stat <= (int_stat & ~((wr_fire && I_PADDR ==
                        dris_pkg::ADDR_INT_CLR) ? I_PWDATA[3:0] : 4'h0))
                        | events;
            O_IRQ    <= |(int_stat & int_en);
        end
    end

    // ----------------------------------------
    // Input buffers and qualification
    // ----------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            O_SE_TERM_SWITCH       <= '0;
            O_DIFF_TERM_SWITCH     <= '0;
            O_BIAS_SWITCH          <= '0;
            O_AC_CAP_BYPASS_SWITCH <= '0;
            O_AMP_DET_EN           <= '0;
            tick_cnt               <= 5'h00;
            tick                   <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_REFS; i++)
            begin
                {O_AMP_DET_EN[i], O_AC_CAP_BYPASS_SWITCH[i],
                 O_BIAS_SWITCH[i], O_DIFF_TERM_SWITCH[i],
                 O_SE_TERM_SWITCH[i]} <= buf_decode(incfg[i*5 + 4],
                                                    incfg[i*5 +: 4]);
            end
            tick     <= (tick_cnt == 5'(dris_pkg::TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 5'(dris_pkg::TICK_CYCLES - 1)) ?
                        5'h00 : tick_cnt + 5'h01;
        end
    end

    for (genvar g = 0; g < NUM_REFS; g++)
    begin : g_qual
        dris_qualifier
        #(
            .VT_W  (dris_pkg::VT_W),
            .MON_W (dris_pkg::MON_W)
        )
        u_qual
        (
            .i_clock    (I_CLOCK),
            .i_resetn   (I_RESETN),
            .i_tick     (tick),
            .i_val_time (valtime[g*8 +: 8]),
            .i_flags    (I_MON_FLAGS[g*4 +: 4]),
            .i_mon_en   (monen[g*4 +: 4]),
            .o_valid    (ref_valid[g])
        );
    end

    // ----------------------------------------
    // Reference selection
    // ----------------------------------------
    assign mode       = dris_pkg::dris_mode_e'(ctrl[1:0]);
    assign man_target = ctrl[dris_pkg::CTRL_PIN_SEL] ? I_MAN_SEL_PINS
                                                      : man_sel;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            compat[i] = (state != dris_pkg::SEL_TRACK)
                        || cmpf[i*4 +: 4] == cmpf[sel*4 +: 4];
    end
    assign elig = ref_valid & compat;
    assign best = pick_best(elig, prio);

    always_comb
    begin
        next_state = state;
        next_sel   = sel;
        if (state == dris_pkg::SEL_TRACK && ref_valid[sel])
        begin
            if (mode == dris_pkg::MODE_AUTO_REV && best[2])
                next_sel = best[1:0];
            else if ((mode == dris_pkg::MODE_MAN_FALLBACK
                      || mode == dris_pkg::MODE_MAN_HOLDOVER)
                     && elig[man_target])
                next_sel = man_target;
        end
        else if (mode == dris_pkg::MODE_MAN_HOLDOVER
                 || mode == dris_pkg::MODE_MAN_FALLBACK)
        begin
            if (ref_valid[man_target])
            begin
                next_state = dris_pkg::SEL_TRACK;
                next_sel   = man_target;
            end
            else if (mode == dris_pkg::MODE_MAN_FALLBACK && best[2])
            begin
                next_state = dris_pkg::SEL_TRACK;
                next_sel   = best[1:0];
            end
            else if (state == dris_pkg::SEL_TRACK)
                next_state = I_TUNE_HIST_VALID ? dris_pkg::SEL_HOLDOVER
                             : dris_pkg::SEL_FREERUN;
        end
        else if (best[2])
        begin
            next_state = dris_pkg::SEL_TRACK;
            next_sel   = best[1:0];
        end
        else if (state == dris_pkg::SEL_TRACK)
            next_state = I_TUNE_HIST_VALID ? dris_pkg::SEL_HOLDOVER
                         : dris_pkg::SEL_FREERUN;
    end

    assign do_switch = next_state == dris_pkg::SEL_TRACK
                       && (state != dris_pkg::SEL_TRACK || next_sel != sel);
    assign events = {valid_prev != ref_valid,
        state == dris_pkg::SEL_TRACK && next_state == dris_pkg::SEL_FREERUN,
        state == dris_pkg::SEL_TRACK && next_state == dris_pkg::SEL_HOLDOVER,
        do_switch};

    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state            <= dris_pkg::SEL_FREERUN;
            sel              <= 2'h0;
            valid_prev       <= 4'h0;
            O_REF_SEL        <= 2'h0;
            O_REF_ACTIVE     <= 1'b0;
            O_HOLDOVER       <= 1'b0;
            O_FREERUN        <= 1'b1;
            O_SWITCHOVER     <= 1'b0;
            O_HITLESS_CANCEL <= 1'b0;
            O_HITLESS_SLEW   <= 1'b0;
            O_PHASE_STEP     <= 1'b0;
            O_REF_CLK        <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            sel          <= next_sel;
            valid_prev   <= ref_valid;
            O_REF_SEL    <= next_sel;
            O_REF_ACTIVE <= next_state == dris_pkg::SEL_TRACK;
            O_HOLDOVER   <= next_state == dris_pkg::SEL_HOLDOVER;
            O_FREERUN    <= next_state == dris_pkg::SEL_FREERUN;
            O_SWITCHOVER <= do_switch;
            O_HITLESS_CANCEL <= do_switch && ctrl[3] && !ctrl[4];
            O_HITLESS_SLEW   <= do_switch && ctrl[3] && ctrl[4];
            O_PHASE_STEP     <= do_switch && !ctrl[3];
            // Clock is resampled, so this path only suits slow references
            O_REF_CLK <= (state == dris_pkg::SEL_TRACK)
                         && I_REF_CLK_IN[sel];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);

    sequence s_tracking_ok;
        state == dris_pkg::SEL_TRACK && ref_valid[sel];
    endsequence
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence

    chk_apb_one_wait: assert property (s_setup |=> O_PREADY ##1 !O_PREADY)
        else $error("apb answer not in first access cycle");
    chk_revert_best: assert property (
        (s_tracking_ok and mode == dris_pkg::MODE_AUTO_REV && best[2]
         && best[1:0] != sel) |=> O_SWITCHOVER && O_REF_SEL == $past(best[1:0]))
        else $error("revertive mode missed a better input");
    chk_nonrev_keeps: assert property (
        (s_tracking_ok and mode == dris_pkg::MODE_AUTO_NONREV) |=> !O_SWITCHOVER)
        else $error("non-revertive mode left a valid input");
    chk_manhold_no_try: assert property (
        (state == dris_pkg::SEL_TRACK && !ref_valid[sel]
         && !ref_valid[man_target] && mode == dris_pkg::MODE_MAN_HOLDOVER)
        |=> !O_REF_ACTIVE)
        else $error("manual holdover mode tried another input");
    chk_holdover_hist: assert property (
        $rose(O_HOLDOVER) |-> $past(I_TUNE_HIST_VALID))
        else $error("holdover entered without history");
    chk_freerun_hist: assert property (
        ($rose(O_FREERUN) && $past(O_REF_ACTIVE)) |-> !$past(I_TUNE_HIST_VALID))
        else $error("free-run entered although history valid");
    chk_switch_event: assert property (
        O_SWITCHOVER |-> O_REF_ACTIVE ##1 (!O_SWITCHOVER || $changed(O_REF_SEL)))
        else $error("switchover event without a change");
    chk_hitless_kind: assert property (
        O_SWITCHOVER |-> $onehot({O_HITLESS_CANCEL, O_HITLESS_SLEW,
                                  O_PHASE_STEP}))
        else $error("switchover without exactly one phase handling");
    chk_irq_level: assert property ($past(|(int_stat & int_en)) == O_IRQ)
        else $error("interrupt output does not follow enabled status");

endmodule

//--- verif/dris_ref_src.sv
// Model of the four reference sources
// Assumes the bench drives i_fault from the clock edge
`timescale 1ns/100ps
module dris_ref_src
(
    // Clock and control
    input  wire logic        i_clock,
    input  wire logic [3:0]  i_fault,
    // Sources
    output logic      [3:0]  o_ref,
    output logic      [15:0] o_flags
);
    logic [3:0] cnt = 4'h0;
    always_ff @(posedge i_clock)
        cnt <= cnt + 4'h1;
    // A faulted source stops and trips every monitor
    always_comb
        for (int i = 0; i < 4; i++)
        begin
            o_ref[i]          = cnt[i] & ~i_fault[i];
            o_flags[4*i +: 4] = {4{i_fault[i]}};
        end
endmodule

//--- verif/tb_top.sv
// Self-checking bench of the reference selector
// Assumes the source model on the reference side
`timescale 1ns/100ps
module tb_top;
    logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
    logic        hist = 0, err, pready, pslverr, rclk, act, hold;
    logic        frun, swo, hc, hs, ps, irq;
    logic [1:0]  pins = 2'h0, sel;
    logic [3:0]  flt = 4'hF, rck, se, dt, bs, by, am;
    logic [7:0]  padr = 8'h00;
    logic [15:0] flg;
    logic [31:0] pwd = 32'h0000_0000, rd, prdata;
    logic        erc = 0;
    int          errors = 0, checks = 0, nsw = 0, nps = 0;
    int          nhc = 0, nhs = 0, nrc = 0;

    dris_ref_src i_src(.i_clock(clk), .i_fault(flt), .o_ref(rck),
        .o_flags(flg));
    dris_top i_dut(.I_CLOCK(clk), .I_RESETN(rstn), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
        .I_PWDATA(pwd), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_REF_CLK_IN(rck), .I_MON_FLAGS(flg),
        .I_MAN_SEL_PINS(pins), .I_TUNE_HIST_VALID(hist),
        .O_SE_TERM_SWITCH(se), .O_DIFF_TERM_SWITCH(dt),
        .O_BIAS_SWITCH(bs), .O_AC_CAP_BYPASS_SWITCH(by),
        .O_AMP_DET_EN(am), .O_REF_CLK(rclk), .O_REF_SEL(sel),
        .O_REF_ACTIVE(act), .O_HOLDOVER(hold), .O_FREERUN(frun),
        .O_SWITCHOVER(swo), .O_HITLESS_CANCEL(hc),
        .O_HITLESS_SLEW(hs), .O_PHASE_STEP(ps), .O_IRQ(irq));

    initial
        forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        nsw += (swo === 1'b1);
        nps += (ps === 1'b1);
        nhc += (hc === 1'b1);
        nhs += (hs === 1'b1);
        // Selected source as it stood one edge earlier
        if (rstn === 1'b1 && rclk !== erc)
            nrc++;
        erc = act === 1'b1 && rck[sel] === 1'b1;
    end

    task automatic conclude();
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("ERROR %s exp %h got %h", s, e, g);
            errors++;
        end
    endtask

    // Request held until pready is sampled high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // Bounded wait for {active, holdover, freerun, sel}
    task automatic wst(logic [4:0] e, logic [4:0] m = 5'h1F);
        int n;
        n = 0;
        while ((({act, hold, frun, sel} ^ e) & m) !== 5'h00 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        chk("state", 32'(e & m), 32'({act, hold, frun, sel} & m));
    endtask

    task automatic t_cfg();
        logic [4:0] c [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
            5'h05, 5'h08, 5'h18, 5'h1C, 5'h06};
        logic [4:0] x [10] = '{5'h01, 5'h05, 5'h09, 5'h0D, 5'h11,
            5'h15, 5'h00, 5'h02, 5'h12, 5'h00};
        for (int i = 0; i < 10; i++)
        begin
            apb(1, 8'h0C, 32'(c[i]));
            repeat (2) @(posedge clk);
            chk("switches", 32'(x[i]), {se[0], dt[0], bs[0], by[0], am[0]});
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        apb(0, 8'h1C, 32'h0000_0000);
        chk("status", 32'h0000_0010, rd);
        t_cfg();
        apb(1, 8'h10, 32'h0000_0000);
        apb(1, 8'h08, 32'h0000_0000);
        flt <= 4'h3;
        wst(5'h12);
        apb(1, 8'h08, 32'h0000_3210);
        flt <= 4'h1;
        wst(5'h11);
        apb(1, 8'h00, 32'h0000_0001);
        flt <= 4'h0;
        repeat (100) @(posedge clk);
        wst(5'h11);
        flt <= 4'h2;
        wst(5'h10);
        hist <= 1'b1;
        apb(1, 8'h04, 32'h0000_0003);
        apb(1, 8'h00, 32'h0000_0002);
        wst(5'h13);
        flt <= 4'hA;
        wst(5'h10);
        flt <= 4'hF;
        wst(5'h08, 5'h1C);
        pins <= 2'h2;
        apb(1, 8'h00, 32'h0000_0007);
        flt <= 4'hE;
        repeat (100) @(posedge clk);
        wst(5'h08, 5'h1C);
        flt <= 4'hA;
        wst(5'h12);
        hist <= 1'b0;
        flt <= 4'hE;
        wst(5'h04, 5'h1C);
        apb(1, 8'h00, 32'h0000_0008);
        wst(5'h10);
        apb(1, 8'h00, 32'h0000_0018);
        flt <= 4'hB;
        wst(5'h12);
        apb(1, 8'h18, 32'h0000_0001);
        flt <= 4'hA;
        repeat (100) @(posedge clk);
        wst(5'h12);
        chk("switchovers", 8, nsw);
        chk("steps", 6, nps);
        chk("cancels", 1, nhc);
        chk("slews", 1, nhs);
        chk("ref_clk", 0, nrc);
        apb(0, 8'h20, 32'h0000_0000);
        chk("int_st", 32'h0000_000F, rd);
        apb(1, 8'h24, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq", 1, irq);
        apb(1, 8'h28, 32'h0000_000F);
        repeat (3) @(posedge clk);
        chk("irq", 0, irq);
        apb(0, 8'h20, 32'h0000_0000);
        chk("int_st", 0, rd);
        apb(0, 8'hFC, 32'h0000_0000);
        chk("slverr", 1, err);
        conclude();
    end

    // Run needs under a thousand cycles
    initial
    begin
        #2000000;
        chk("watchdog", 32'h0000_0000, 32'h0000_0001);
        conclude();
    end
endmodule
